//--- pkg/lbac_defines.svh
// timing counts, table codes and loop constants for the boost control block
`ifndef LBAC_DEFINES_SVH
`define LBAC_DEFINES_SVH

`define LBAC_CLK_PERIOD_NS 5
// minimum switch times, ns, per frequency band
`define LBAC_LO_TOFF_NS 150
`define LBAC_LO_TON_NS 150
`define LBAC_HI_TOFF_NS 40
`define LBAC_HI_TON_NS 110
// least times round up to whole cycles
`define LBAC_CYC_UP(ns) (((ns) + `LBAC_CLK_PERIOD_NS - 1) / `LBAC_CLK_PERIOD_NS)
`define LBAC_LO_TOFF_CYC `LBAC_CYC_UP(`LBAC_LO_TOFF_NS)
`define LBAC_LO_TON_CYC `LBAC_CYC_UP(`LBAC_LO_TON_NS)
`define LBAC_HI_TOFF_CYC `LBAC_CYC_UP(`LBAC_HI_TOFF_NS)
`define LBAC_HI_TON_CYC `LBAC_CYC_UP(`LBAC_HI_TON_NS)
// boost frequencies in kHz; table index = boost_freq_resistor code
`define LBAC_F0_KHZ 400
`define LBAC_F1_KHZ 200
`define LBAC_F2_KHZ 303
`define LBAC_F3_KHZ 100
`define LBAC_F4_KHZ 500
`define LBAC_F5_KHZ 1818
`define LBAC_F6_KHZ 2000
`define LBAC_F7_KHZ 2222
`define LBAC_CLK_KHZ 200000
// first code of the fast band
`define LBAC_HI_BAND_CODE 3'h5
// boost reference, 12-bit, min..max; initial level about 88 percent
`define LBAC_REF_MAX 12'hFFF
`define LBAC_REF_MIN 12'h000
`define LBAC_REF_INIT 12'hE14
// sink sampling interval in cycles
`define LBAC_SAMPLE_CYC 16'h03E8
// sync presence: edges seen in the detection window
`define LBAC_DET_CYC 16'h2710
`define LBAC_DET_EDGES 4'h4
// sync clock lost after this many cycles without an edge
`define LBAC_SYNC_LOSS_CYC 16'h1000
`define LBAC_NUM_SINKS 4
`endif

//--- pkg/lbac_pkg.sv
// types for the boost control block
package lbac_pkg;
  typedef enum logic [1:0] {
    LBAC_OFF,
    LBAC_DETECT,
    LBAC_INIT_RAMP,
    LBAC_ADAPT
  } lbac_state_t;
  typedef enum logic [1:0] {
    LBAC_SEL_1,
    LBAC_SEL_2,
    LBAC_SEL_3,
    LBAC_SEL_4
  } lbac_strings_t;
endpackage

//--- rtl/lbac_switch_timer.sv
// one switching cycle of the boost: period, current limit, min on/off
`timescale 1ns/10ps
`include "lbac_defines.svh"
module lbac_switch_timer
  import lbac_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [2:0] freq_code,
  input wire logic ext_tick,
  input wire logic use_ext,
  input wire logic ilimit_hit,
  input wire logic pwm_off_req,
  // result
  output logic gate,
  output logic cycle_start
);
  logic [11:0] period;
  logic [11:0] cnt;
  logic [7:0] on_cnt;
  logic [7:0] off_cnt;
  logic [7:0] min_on;
  logic [7:0] min_off;
  logic int_tick;
  logic start;
  logic cut;
  logic max_duty;

  always_comb begin
    unique case (freq_code)
      3'h0: period = 12'(`LBAC_CLK_KHZ / `LBAC_F0_KHZ);
      3'h1: period = 12'(`LBAC_CLK_KHZ / `LBAC_F1_KHZ);
      3'h2: period = 12'(`LBAC_CLK_KHZ / `LBAC_F2_KHZ);
      3'h3: period = 12'(`LBAC_CLK_KHZ / `LBAC_F3_KHZ);
      3'h4: period = 12'(`LBAC_CLK_KHZ / `LBAC_F4_KHZ);
      3'h5: period = 12'(`LBAC_CLK_KHZ / `LBAC_F5_KHZ);
      3'h6: period = 12'(`LBAC_CLK_KHZ / `LBAC_F6_KHZ);
      3'h7: period = 12'(`LBAC_CLK_KHZ / `LBAC_F7_KHZ);
    endcase
  end

  // band limits; 2000 kHz shares the fast band values
  always_comb begin
    if (freq_code >= `LBAC_HI_BAND_CODE) begin
      min_on = 8'(`LBAC_HI_TON_CYC);
      min_off = 8'(`LBAC_HI_TOFF_CYC);
    end else begin
      min_on = 8'(`LBAC_LO_TON_CYC);
      min_off = 8'(`LBAC_LO_TOFF_CYC);
    end
  end

  assign int_tick = (cnt == period - 12'h001);
  assign start = run && (use_ext ? ext_tick : int_tick);
  assign cycle_start = start;
  // loop request is idle at the top, so end each pulse early enough that
  // the next start finds min off-time behind it; internal clock only
  assign max_duty = !use_ext
                    && (cnt >= period - 12'(min_off) - 12'h002);
  // limit and loop request end the pulse, never before min on-time
  assign cut = (ilimit_hit || pwm_off_req || max_duty)
               && (on_cnt >= min_on);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 12'h000;
    end else if (!run || start) begin
      cnt <= 12'h000;
    end else begin
      cnt <= cnt + 12'h001;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gate <= 1'b0;
      on_cnt <= 8'h00;
      off_cnt <= 8'h00;
    end else if (!run) begin
      gate <= 1'b0;
      on_cnt <= 8'h00;
      off_cnt <= 8'hFF;
    end else if (start && off_cnt >= min_off) begin
      gate <= 1'b1;
      on_cnt <= 8'h00;
    end else if (gate && cut) begin
      gate <= 1'b0;
      off_cnt <= 8'h00;
    end else if (gate) begin
      on_cnt <= (on_cnt == 8'hFF) ? on_cnt : on_cnt + 8'h01;
    end else begin
      off_cnt <= (off_cnt == 8'hFF) ? off_cnt : off_cnt + 8'h01;
    end
  end
endmodule

//--- rtl/lbac_top.sv
// boost control: enable, sync, pump status, fault pin, adaptive loop
// Summary of operation
// - device runs only while enable is high, stops when it falls
// - bus and fault detection idle while disabled; both run when enabled
// - at start-up detect external sync clock, else use internal oscillator
// - static high sync pin enables spread spectrum, low disables it
// - brightness from dim input duty by default, bus may override
// - fault output is open drain, pulls low only
// - charge pump enabled unless pump supply tied to main supply
// - with pump enabled, report flying capacitor detection flag
// - with pump enabled, pump fault sets flag and asserts fault output
// - pump interrupt enable gates output; flag still recorded
// - boost frequency picked from eight-entry resistor table
// - current limit cuts switch once min on-time has passed, restart next cycle
// - current limit sets no flag and no fault output
// - minimum on and off times per frequency band
// - loop watches only sinks active by string count
// - open or shorted strings excluded from the loop
// - sinks sampled periodically; raise boost if any below headroom
// - otherwise step boost down until a sink touches headroom
// - ramp to about 88 percent level before sinks active
// - dimming mode, strings, dim frequency from setting resistors
// - latched faults cleared by bus command or enable falling edge
// - sink phases spaced by 360 degrees over string count
// - spread spectrum off from one cycle after external sync mode is taken
`timescale 1ns/10ps
`include "lbac_defines.svh"
module lbac_top
  import lbac_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // pins
  input wire logic enable_in,
  input wire logic boost_sync_in,
  input wire logic dim_pwm_in,
  input wire logic pump_supply_pin,
  input wire logic flycap_sense,
  input wire logic pump_fault_in,
  input wire logic switch_sense_pin,
  // setting resistor codes, decoded by the analog front end
  input wire logic [2:0] boost_freq_resistor,
  input wire logic [2:0] dim_freq_resistor,
  input wire logic [1:0] string_count_resistor,
  input wire logic [1:0] dim_mode_resistor,
  // sink status
  input wire logic [3:0] sink_below_headroom,
  input wire logic [3:0] sink_at_headroom,
  input wire logic [3:0] string_fault,
  input wire logic sinks_active,
  // bus side controls
  input wire logic bus_bright_sel,
  input wire logic [15:0] bus_bright,
  input wire logic pump_irq_enable,
  input wire logic fault_clear,
  // status
  output logic device_on,
  output logic bus_active,
  output logic fault_detect_on,
  output logic ext_sync_mode,
  output logic spread_enable,
  output logic pump_enable,
  output logic flycap_detect_flag,
  output logic pump_fault_flag,
  output logic [2:0] boost_freq_sel,
  output logic [2:0] dim_freq_sel,
  output logic [1:0] dim_mode,
  output logic [3:0] sink_used,
  output logic [1:0] phase_step,
  output logic bright_src_bus,
  output logic [15:0] bright_level,
  output logic [11:0] boost_ref,
  output logic boost_gate,
  // open-drain fault output
  output logic fault_int_out,
  output logic fault_int_oe
);
  lbac_state_t state;
  logic [1:0] en_s;
  logic [1:0] sync_s;
  logic [1:0] pwm_s;
  logic [1:0] ps_s;
  logic [1:0] fc_s;
  logic [1:0] pf_s;
  logic [1:0] is_s;
  logic en_d;
  logic sync_d;
  logic pwm_d;
  logic en_fall;
  logic sync_rise;
  logic [15:0] det_cnt;
  logic [3:0] edge_cnt;
  logic [15:0] loss_cnt;
  logic [15:0] samp_cnt;
  logic [15:0] hi_cnt;
  logic [15:0] per_cnt;
  logic [3:0] monitored;
  logic cyc_start;
  logic run;

  // two-flop synchronisers for pins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_s <= 2'h0;
      sync_s <= 2'h0;
      pwm_s <= 2'h0;
      ps_s <= 2'h0;
      fc_s <= 2'h0;
      pf_s <= 2'h0;
      is_s <= 2'h0;
    end else begin
      en_s <= {en_s[0], enable_in};
      sync_s <= {sync_s[0], boost_sync_in};
      pwm_s <= {pwm_s[0], dim_pwm_in};
      ps_s <= {ps_s[0], pump_supply_pin};
      fc_s <= {fc_s[0], flycap_sense};
      pf_s <= {pf_s[0], pump_fault_in};
      is_s <= {is_s[0], switch_sense_pin};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_d <= 1'b0;
      sync_d <= 1'b0;
      pwm_d <= 1'b0;
    end else begin
      en_d <= en_s[1];
      sync_d <= sync_s[1];
      pwm_d <= pwm_s[1];
    end
  end

  assign en_fall = en_d && !en_s[1];
  assign sync_rise = sync_s[1] && !sync_d;

  assign device_on = (state != LBAC_OFF);
  assign bus_active = device_on;
  assign fault_detect_on = device_on;
  assign run = (state == LBAC_INIT_RAMP) || (state == LBAC_ADAPT);

  // main sequence
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= LBAC_OFF;
    end else if (!en_s[1]) begin
      state <= LBAC_OFF;
    end else begin
      unique case (state)
        LBAC_OFF: state <= LBAC_DETECT;
        LBAC_DETECT: begin
          if (det_cnt == `LBAC_DET_CYC) begin
            state <= LBAC_INIT_RAMP;
          end
        end
        LBAC_INIT_RAMP: begin
          if (sinks_active && boost_ref == `LBAC_REF_INIT) begin
            state <= LBAC_ADAPT;
          end
        end
        LBAC_ADAPT: begin
          if (!sinks_active) begin
            state <= LBAC_INIT_RAMP;
          end
        end
      endcase
    end
  end

  // sync clock detection window at start-up
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      det_cnt <= 16'h0000;
      edge_cnt <= 4'h0;
    end else if (state != LBAC_DETECT) begin
      det_cnt <= 16'h0000;
      edge_cnt <= 4'h0;
    end else begin
      det_cnt <= det_cnt + 16'h0001;
      if (sync_rise && edge_cnt != 4'hF) begin
        edge_cnt <= edge_cnt + 4'h1;
      end
    end
  end

  // external mode chosen at start-up, dropped if the clock stops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_sync_mode <= 1'b0;
      loss_cnt <= 16'h0000;
    end else if (state == LBAC_DETECT) begin
      loss_cnt <= 16'h0000;
      if (det_cnt == `LBAC_DET_CYC) begin
        ext_sync_mode <= (edge_cnt >= `LBAC_DET_EDGES);
      end
    end else if (!device_on) begin
      ext_sync_mode <= 1'b0;
      loss_cnt <= 16'h0000;
    end else if (ext_sync_mode) begin
      if (sync_rise) begin
        loss_cnt <= 16'h0000;
      end else if (loss_cnt == `LBAC_SYNC_LOSS_CYC) begin
        ext_sync_mode <= 1'b0;
      end else begin
        loss_cnt <= loss_cnt + 16'h0001;
      end
    end
  end

  // static level selects spreading; forced off from one cycle after ext_sync_mode sets
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      spread_enable <= 1'b0;
    end else begin
      spread_enable <= device_on && !ext_sync_mode
                       && sync_s[1];
    end
  end

  // strap codes followed through the detection window, then held
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boost_freq_sel <= 3'h0;
      dim_freq_sel <= 3'h0;
      dim_mode <= 2'h0;
      sink_used <= 4'h0;
      phase_step <= 2'h0;
      pump_enable <= 1'b0;
    end else if (state == LBAC_DETECT) begin
      boost_freq_sel <= boost_freq_resistor;
      dim_freq_sel <= dim_freq_resistor;
      dim_mode <= dim_mode_resistor;
      // pump off when its supply pin is tied to main supply
      pump_enable <= !ps_s[1];
      unique case (lbac_strings_t'(string_count_resistor))
        LBAC_SEL_1: sink_used <= 4'h1;
        LBAC_SEL_2: sink_used <= 4'h3;
        LBAC_SEL_3: sink_used <= 4'h7;
        LBAC_SEL_4: sink_used <= 4'hF;
      endcase
      // phase step carries the string count code; three strings use 120 degrees
      phase_step <= string_count_resistor;
    end
  end

  // brightness: duty of dim input by default, bus when selected
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
      bright_level <= 16'h0000;
      bright_src_bus <= 1'b0;
    end else if (!device_on) begin
      per_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
      bright_src_bus <= 1'b0;
    end else begin
      bright_src_bus <= bus_bright_sel;
      if (pwm_s[1] && !pwm_d) begin
        per_cnt <= 16'h0000;
        hi_cnt <= 16'h0001;
        if (!bus_bright_sel) begin
          // high time in cycles; scaled by the dimming stage
          bright_level <= hi_cnt;
        end
      end else begin
        per_cnt <= per_cnt + 16'h0001;
        if (pwm_s[1] && hi_cnt != 16'hFFFF) begin
          hi_cnt <= hi_cnt + 16'h0001;
        end
      end
      if (bus_bright_sel) begin
        bright_level <= bus_bright;
      end
    end
  end

  // pump status flags; hardware set wins over clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flycap_detect_flag <= 1'b0;
      pump_fault_flag <= 1'b0;
    end else if (!device_on) begin
      flycap_detect_flag <= 1'b0;
    end else begin
      flycap_detect_flag <= pump_enable && fc_s[1];
      if (fault_detect_on && pump_enable && pf_s[1]) begin
        pump_fault_flag <= 1'b1;
      end else if (fault_clear || en_fall) begin
        pump_fault_flag <= 1'b0;
      end
    end
  end

  // current limit only cuts the gate; no flag path exists
  assign fault_int_out = 1'b0;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fault_int_oe <= 1'b0;
    end else begin
      // pull low while an enabled flag stands
      fault_int_oe <= pump_fault_flag && pump_irq_enable;
    end
  end

  // faulted strings drop out so an open string cannot run boost to max
  assign monitored = sink_used & ~string_fault;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      samp_cnt <= 16'h0000;
    end else if (!run || samp_cnt == `LBAC_SAMPLE_CYC) begin
      samp_cnt <= 16'h0000;
    end else begin
      samp_cnt <= samp_cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boost_ref <= `LBAC_REF_MIN;
    end else if (!device_on) begin
      boost_ref <= `LBAC_REF_MIN;
    end else if (state == LBAC_INIT_RAMP) begin
      if (boost_ref < `LBAC_REF_INIT) begin
        boost_ref <= boost_ref + 12'h001;
      end else if (boost_ref > `LBAC_REF_INIT) begin
        boost_ref <= boost_ref - 12'h001;
      end
    end else if (state == LBAC_ADAPT && samp_cnt == `LBAC_SAMPLE_CYC) begin
      if (|(monitored & sink_below_headroom)) begin
        if (boost_ref != `LBAC_REF_MAX) begin
          boost_ref <= boost_ref + 12'h001;
        end
      end else if (!(|(monitored & sink_at_headroom))) begin
        if (boost_ref != `LBAC_REF_MIN) begin
          boost_ref <= boost_ref - 12'h001;
        end
      end
    end
  end

  lbac_switch_timer u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(run),
    .freq_code(boost_freq_sel),
    .ext_tick(sync_rise),
    .use_ext(ext_sync_mode),
    .ilimit_hit(is_s[1]),
    .pwm_off_req(1'b0),
    .gate(boost_gate),
    .cycle_start(cyc_start)
  );
endmodule

//--- dv/lbac_sva.sv
// port-level assertions for the boost control block
`timescale 1ns/10ps
module lbac_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // pins and the bus pump interrupt enable
  input wire logic enable_in,
  input wire logic pump_fault_in,
  input wire logic switch_sense_pin,
  input wire logic pump_irq_enable,
  // status
  input wire logic device_on,
  input wire logic bus_active,
  input wire logic fault_detect_on,
  input wire logic ext_sync_mode,
  input wire logic spread_enable,
  input wire logic pump_enable,
  input wire logic pump_fault_flag,
  input wire logic [11:0] boost_ref,
  input wire logic boost_gate,
  input wire logic fault_int_out,
  input wire logic fault_int_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_stays_off: assert property (!enable_in [*3] |=> !device_on)
    else $error("device on without enable");
  a_turns_on: assert property (enable_in [*3] |=> device_on)
    else $error("device off with enable held");
  a_bus_idle: assert property (
    bus_active == device_on && fault_detect_on == device_on)
    else $error("bus or fault detection out of step with enable");
  a_never_high: assert property (fault_int_out == 1'b0)
    else $error("fault pin driven high");
  a_irq_sets: assert property (
    (pump_fault_flag && pump_irq_enable) [*4] |=> fault_int_oe)
    else $error("pump fault not raised on fault pin");
  a_irq_masked: assert property (
    !pump_irq_enable [*4] |=> !fault_int_oe)
    else $error("masked pump fault pulls fault pin");
  a_pin_release: assert property (
    !pump_fault_flag [*2] |=> !fault_int_oe)
    else $error("fault pin held with no flag");
  a_flag_gated: assert property (
    !pump_enable && !$past(pump_enable) |-> !$rose(pump_fault_flag))
    else $error("pump flag set with pump off");
  a_limit_quiet: assert property (
    !pump_fault_in [*4] |-> !$rose(pump_fault_flag))
    else $error("flag set without pump fault");
  a_limit_cuts: assert property (
    switch_sense_pin [*3] |-> ##[0:34] !boost_gate)
    else $error("switch not cut at current limit");
  a_ref_steps: assert property (
    $changed(boost_ref) && boost_ref != 12'h000 && $past(device_on)
    |-> (boost_ref == $past(boost_ref) + 12'h001
      || boost_ref == $past(boost_ref) - 12'h001))
    else $error("boost reference jumped");
  a_sync_spread: assert property (
    ext_sync_mode && $past(ext_sync_mode) |-> !spread_enable)
    else $error("spread on with external sync");
endmodule

bind lbac_top lbac_sva chk_u (
  .mclk, .rst_b, .enable_in, .pump_fault_in, .switch_sense_pin,
  .pump_irq_enable, .device_on, .bus_active, .fault_detect_on,
  .ext_sync_mode, .spread_enable, .pump_enable, .pump_fault_flag,
  .boost_ref, .boost_gate, .fault_int_out, .fault_int_oe
);

//--- dv/lbac_host_model.sv
// host side stand-in: enable, brightness, bus controls, sync clock, pull-up
`timescale 1ns/10ps
module lbac_host_model (
  // clock
  input wire logic mclk,
  // to the device
  output logic enable_in,
  output logic boost_sync_in,
  output logic dim_pwm_in,
  output logic bus_bright_sel,
  output logic [15:0] bus_bright,
  output logic pump_irq_enable,
  output logic fault_clear,
  // open-drain fault line
  input wire logic fault_int_out,
  input wire logic fault_int_oe,
  output logic fault_line
);
  logic sync_run = 1'b0;
  // pull-up holds the line high whenever the device lets go
  assign fault_line = fault_int_oe ? fault_int_out : 1'b1;
  initial begin
    enable_in = 1'b0;
    boost_sync_in = 1'b0;
    dim_pwm_in = 1'b0;
    bus_bright_sel = 1'b0;
    bus_bright = 16'h0000;
    pump_irq_enable = 1'b0;
    fault_clear = 1'b0;
  end
  // 1 MHz sync, edges fall on mclk falling edges
  always begin
    #500;
    if (sync_run) begin
      boost_sync_in = ~boost_sync_in;
    end
  end
  // callers enter just after a clock edge
  task automatic set_ctrl(input logic en, input logic irq, input logic sel,
      input logic [15:0] val);
    enable_in = en;
    pump_irq_enable = irq;
    bus_bright_sel = sel;
    bus_bright = val;
  endtask
  task automatic set_sync(input logic level, input logic run);
    sync_run = run;
    boost_sync_in = level;
  endtask
  task automatic pulse_clear();
    fault_clear = 1'b1;
    @(posedge mclk);
    #1;
    fault_clear = 1'b0;
  endtask
  task automatic pwm_period(input int hi, input int lo);
    dim_pwm_in = 1'b1;
    repeat (hi) @(posedge mclk);
    #1;
    dim_pwm_in = 1'b0;
    repeat (lo) @(posedge mclk);
    #1;
  endtask
endmodule

//--- dv/led_boost_adaptive_control_bench.sv
// self-checking bench for the boost control block
`timescale 1ns/10ps
module led_boost_adaptive_control_bench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  wire enable_in, boost_sync_in, dim_pwm_in, bus_bright_sel;
  wire pump_irq_enable, fault_clear, fault_line;
  wire [15:0] bus_bright;
  logic pump_supply_pin = 1'b0;
  logic flycap_sense = 1'b1;
  logic pump_fault_in = 1'b0;
  logic switch_sense_pin = 1'b0;
  logic [2:0] boost_freq_resistor = 3'h5;
  logic [2:0] dim_freq_resistor = 3'h3;
  logic [1:0] string_count_resistor = 2'h2;
  logic [1:0] dim_mode_resistor = 2'h2;
  logic [3:0] sink_below_headroom = 4'h0;
  logic [3:0] sink_at_headroom = 4'h1;
  logic [3:0] string_fault = 4'h0;
  logic sinks_active = 1'b0;
  logic device_on, bus_active, fault_detect_on, ext_sync_mode;
  logic spread_enable, pump_enable, flycap_detect_flag, pump_fault_flag;
  logic [2:0] boost_freq_sel, dim_freq_sel;
  logic [1:0] dim_mode, phase_step;
  logic [3:0] sink_used;
  logic bright_src_bus, boost_gate, fault_int_out, fault_int_oe;
  logic [15:0] bright_level;
  logic [11:0] boost_ref;
  int mismatches = 0;
  int compares = 0;

  always #2.5 mclk = ~mclk;

  lbac_top dut_u (
    .mclk, .rst_b, .enable_in, .boost_sync_in, .dim_pwm_in,
    .pump_supply_pin, .flycap_sense, .pump_fault_in, .switch_sense_pin,
    .boost_freq_resistor, .dim_freq_resistor, .string_count_resistor,
    .dim_mode_resistor, .sink_below_headroom, .sink_at_headroom,
    .string_fault, .sinks_active, .bus_bright_sel, .bus_bright,
    .pump_irq_enable, .fault_clear, .device_on, .bus_active,
    .fault_detect_on, .ext_sync_mode, .spread_enable, .pump_enable,
    .flycap_detect_flag, .pump_fault_flag, .boost_freq_sel, .dim_freq_sel,
    .dim_mode, .sink_used, .phase_step, .bright_src_bus, .bright_level,
    .boost_ref, .boost_gate, .fault_int_out, .fault_int_oe
  );
  lbac_host_model host_u (
    .mclk, .enable_in, .boost_sync_in, .dim_pwm_in, .bus_bright_sel,
    .bus_bright, .pump_irq_enable, .fault_clear, .fault_int_out,
    .fault_int_oe, .fault_line
  );

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // power-up, strap decode during the detection window, static-high sync
  task automatic t_power_up();
    host_u.set_sync(1'b1, 1'b0);
    host_u.set_ctrl(1'b1, 1'b0, 1'b0, 16'h0000);
    tick(2);
    check("on_early", 16'(device_on), 16'h0);
    tick(1);
    check("on", 16'(device_on), 16'h1);
    check("bus", 16'(bus_active & fault_detect_on), 16'h1);
    for (int c = 0; c < 8; c++) begin
      boost_freq_resistor = 3'(c);
      tick(4);
      check("freq_sel", 16'(boost_freq_sel), 16'(c));
    end
    for (int c = 0; c < 4; c++) begin
      string_count_resistor = 2'(c);
      tick(4);
      check("sink_used", 16'(sink_used), 16'((2 << c) - 1));
      check("phase", 16'(phase_step), 16'(c));
    end
    boost_freq_resistor = 3'h5;
    string_count_resistor = 2'h2;
    tick(4);
    check("dim_sel", 16'({dim_freq_sel, dim_mode}), 16'h0E);
    check("pump_on", 16'(pump_enable), 16'h1);
    check("flycap", 16'(flycap_detect_flag), 16'h1);
    tick(10010);
    check("spread", 16'({ext_sync_mode, spread_enable}), 16'h1);
  endtask

  // pump fault flag, interrupt mask, bus clear
  task automatic t_pump();
    pump_fault_in = 1'b1;
    tick(5);
    pump_fault_in = 1'b0;
    tick(3);
    check("masked", 16'({pump_fault_flag, fault_int_oe}), 16'h2);
    host_u.set_ctrl(1'b1, 1'b1, 1'b0, 16'h0000);
    tick(5);
    check("line_low", 16'({fault_int_oe, fault_line}), 16'h2);
    host_u.pulse_clear();
    tick(4);
    check("cleared", 16'({pump_fault_flag, fault_line}), 16'h1);
  endtask

  // ramp to the initial level, then the adaptive loop
  task automatic t_adapt();
    logic [11:0] prev;
    sinks_active = 1'b1;
    for (int i = 0; i < 5000 && boost_ref !== 12'hE14; i++) begin
      tick(1);
    end
    check("init_ref", 16'(boost_ref), 16'h0E14);
    sink_below_headroom = 4'h8;
    tick(2100);
    check("unused", 16'(boost_ref), 16'h0E14);
    sink_below_headroom = 4'h2;
    string_fault = 4'h2;
    tick(2100);
    check("excluded", 16'(boost_ref), 16'h0E14);
    string_fault = 4'h0;
    tick(2100);
    check("raised", 16'(boost_ref > 12'hE14), 16'h1);
    prev = boost_ref;
    sink_below_headroom = 4'h0;
    sink_at_headroom = 4'h0;
    tick(2100);
    check("lowered", 16'(boost_ref < prev), 16'h1);
    sink_at_headroom = 4'h1;
  endtask

  // limit held: short on-times, restarts each cycle, no flag
  task automatic t_limit(input int lo, input int hi);
    int run;
    int worst;
    int rises;
    logic last;
    run = 0;
    worst = 0;
    rises = 0;
    last = boost_gate;
    switch_sense_pin = 1'b1;
    tick(4);
    repeat (1000) begin
      tick(1);
      run = (boost_gate === 1'b1) ? run + 1 : 0;
      if (run > worst) worst = run;
      if (boost_gate === 1'b1 && last !== 1'b1) rises++;
      last = boost_gate;
    end
    switch_sense_pin = 1'b0;
    check("restarts", 16'(rises >= 2), 16'h1);
    check("min_on", 16'(worst >= lo && worst <= hi), 16'h1);
    check("no_flag", 16'({pump_fault_flag, fault_int_oe}), 16'h0);
  endtask

  // enable falling edge clears a latched fault and stops the device
  task automatic t_off();
    pump_fault_in = 1'b1;
    tick(5);
    pump_fault_in = 1'b0;
    host_u.set_ctrl(1'b0, 1'b1, 1'b0, 16'h0000);
    sinks_active = 1'b0;
    tick(4);
    check("off", 16'({device_on, bus_active}), 16'h0);
    check("off_clear", 16'({pump_fault_flag, fault_line}), 16'h1);
  endtask

  // external sync clock, then brightness from dim input and from bus
  task automatic t_sync();
    host_u.set_sync(1'b0, 1'b1);
    host_u.set_ctrl(1'b1, 1'b1, 1'b0, 16'h0000);
    tick(10015);
    check("ext", 16'({ext_sync_mode, spread_enable}), 16'h2);
    host_u.pwm_period(100, 100);
    host_u.pwm_period(100, 100);
    tick(5);
    check("pwm_bright", bright_level, 16'h0064);
    check("pwm_src", 16'(bright_src_bus), 16'h0);
    host_u.set_ctrl(1'b1, 1'b1, 1'b1, 16'h1234);
    tick(5);
    check("bus_bright", bright_level, 16'h1234);
    check("bus_src", 16'(bright_src_bus), 16'h1);
    host_u.set_ctrl(1'b0, 1'b1, 1'b0, 16'h0000);
    host_u.set_sync(1'b0, 1'b0);
    tick(5);
  endtask

  // sync pin low and pump supply tied: no spread, pump off, faults ignored
  task automatic t_low();
    pump_supply_pin = 1'b1;
    boost_freq_resistor = 3'h4;
    host_u.set_ctrl(1'b1, 1'b1, 1'b0, 16'h0000);
    tick(10015);
    check("no_spread", 16'({ext_sync_mode, spread_enable}), 16'h0);
    check("pump_off", 16'(pump_enable), 16'h0);
    pump_fault_in = 1'b1;
    tick(6);
    check("pump_gated", 16'({pump_fault_flag, fault_line}), 16'h1);
    pump_fault_in = 1'b0;
  endtask

  initial begin
    tick(10);
    check("rst", 16'({device_on, fault_int_oe, boost_ref}), 16'h0);
    rst_b = 1'b1;
    tick(2);
    t_power_up();
    t_pump();
    t_adapt();
    t_limit(22, 25);
    t_off();
    t_sync();
    t_low();
    t_limit(30, 33);
    print_verdict();
  end

  // run takes about 45k cycles
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end
endmodule
